// ===== owm_pkg.sv
/*
 * owm_pkg: constants and carrier types for the single-wire link master.
 * assumes a 250 MHz system clock; all times are turned into cycle counts here.
 */
package owm_pkg;

    localparam int unsigned CLK_MHZ = 250;

    // times in microseconds (hard reset in milliseconds) as printed, counts derived (least times round up)
    localparam int unsigned RESET_LOW_US = 480;
    localparam int unsigned HARD_RESET_MS = 5;
    localparam int unsigned PRESENCE_CHECK_US = 10;
    localparam int unsigned PRESENCE_WIN_US = 240;
    localparam int unsigned SLOT_US = 65;
    localparam int unsigned WRITE_SLOT_STROBE_US = 1;
    localparam int unsigned READ_SLOT_STROBE_US = 1;
    localparam int unsigned READ_SAMPLE_US = 13;
    localparam int unsigned WRITE_ZERO_LOW_US = 60;
    localparam int unsigned RECOVERY_US = 5;

    localparam int unsigned RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
    localparam int unsigned HARD_RESET_CYC = HARD_RESET_MS * 1000 * CLK_MHZ + 1;
    localparam int unsigned PRESENCE_CHECK_CYC = PRESENCE_CHECK_US * CLK_MHZ;
    localparam int unsigned PRESENCE_WIN_CYC = PRESENCE_WIN_US * CLK_MHZ;
    localparam int unsigned SLOT_CYC = SLOT_US * CLK_MHZ;
    localparam int unsigned WRITE_SLOT_STROBE_CYC = WRITE_SLOT_STROBE_US * CLK_MHZ;
    localparam int unsigned READ_SLOT_STROBE_CYC = READ_SLOT_STROBE_US * CLK_MHZ;
    localparam int unsigned READ_SAMPLE_CYC = READ_SAMPLE_US * CLK_MHZ;
    localparam int unsigned WRITE_ZERO_LOW_CYC = WRITE_ZERO_LOW_US * CLK_MHZ;
    localparam int unsigned RECOVERY_CYC = RECOVERY_US * CLK_MHZ;

    // command codes, profile answer, check polynomial and start value
    localparam logic [7:0] CMD_READ_ROM = 8'h33;
    localparam logic [7:0] CMD_SKIP_ROM = 8'hCC;
    localparam logic [7:0] CMD_PROFILE = 8'h99;
    localparam logic [7:0] PROFILE_ANSWER = 8'h55;
    localparam logic [7:0] CMD_PROGRAM = 8'h5A;
    localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // request operations
    typedef enum logic [2:0] {
        OWM_OP_RESET = 3'b000,
        OWM_OP_HARD_RESET = 3'b001,
        OWM_OP_WRITE = 3'b010,
        OWM_OP_READ = 3'b011,
        OWM_OP_CRC_CLR = 3'b100
    } owm_op_type;

    typedef struct packed {
        owm_op_type op;
        logic [7:0] data;
    } owm_req_type;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] crc;
        logic presence;
        logic line_stuck;
    } owm_rsp_type;

endpackage : owm_pkg

// ===== owm_skid.sv
/*
 * owm_skid: two-entry valid/ready buffer for answer words.
 * assumes one clock; source and sink follow valid/ready handshakes.
 */
`timescale 1ns/100ps
module owm_skid import owm_pkg::*; #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 2
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    initial begin
        if (DEPTH != 2) begin
            $error("owm_skid supports DEPTH of 2 only");
        end
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    assign push = i_in_valid && (count_reg != 2'h2);
    assign pop = (count_reg != 2'h0) && i_out_ready;
    assign o_in_ready = (count_reg != 2'h2);
    assign o_out_valid = (count_reg != 2'h0);
    assign o_out_data = mem_reg[rd_ptr_reg];

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // storage has no reset; only valid entries are ever read
    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

endmodule : owm_skid

// ===== owm_master.sv
/*
 * owm_master: host-side master for a single open-drain data line with
 * reset/presence, byte write and byte read slots and a running 8-bit check.
 * assumes an external pull-up on the line and a line input synchronous to i_mclk.
 */
//
// Contract
// - profile query 99h answered with 55h
// - 480us low reset, then presence pulse
// - write slot: strobe, then hold or release
// - read slot: strobe, device drives zero
// - idle high line pauses, resumes safely
// - check polynomial x8+x5+x4+1
// - host computes own check and compares; the master only returns crc in each answer and compares nothing
// - sample line high 10us after release
// - hard reset over 5ms after power
// - bytes travel least significant bit first
`timescale 1ns/100ps
module owm_master import owm_pkg::*; #(
    parameter int unsigned HARD_RESET_CYCLES = HARD_RESET_CYC,
    parameter int unsigned RESET_CYCLES = RESET_LOW_CYC,
    parameter int unsigned PRESENCE_WIN_CYCLES = PRESENCE_WIN_CYC,
    parameter int unsigned SLOT_CYCLES = SLOT_CYC
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire owm_req_type i_req,
    output logic o_rsp_valid,
    input wire logic i_rsp_ready,
    output owm_rsp_type o_rsp,
    output logic o_busy,
    input wire logic i_line,
    output logic o_line,
    output logic o_line_oe
);
    localparam int CW = 24;

    initial begin
        if (RESET_CYCLES < 2 || SLOT_CYCLES <= READ_SAMPLE_CYC + RECOVERY_CYC
            || HARD_RESET_CYCLES >= (1 << CW) || RESET_CYCLES >= (1 << CW)
            || PRESENCE_WIN_CYCLES <= PRESENCE_CHECK_CYC) begin
            $error("owm_master timing parameters out of range");
        end
    end

    // ----------------------------------------------------------------
    // check value step
    // ----------------------------------------------------------------
    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic bit_in);
        logic fb;
        fb = crc[0] ^ bit_in;
        crc_step = {1'b0, crc[7:1]} ^ (fb ? CRC_POLY_REFL : 8'h00);
    endfunction : crc_step

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_RST_LOW = 4'b0001,
        ST_RST_CHECK = 4'b0010,
        ST_RST_WAIT = 4'b0011,
        ST_SLOT_LOW = 4'b0100,
        ST_SLOT_HOLD = 4'b0101,
        ST_SLOT_REC = 4'b0110,
        ST_EMIT = 4'b0111
    } owm_state_type;

    owm_state_type state_reg;
    owm_op_type op_reg;
    logic [CW-1:0] cnt_reg;
    logic [7:0] shift_reg;
    logic [2:0] bit_reg;
    logic [7:0] crc_reg;
    logic presence_reg;
    logic stuck_reg;
    logic line_oe_reg;
    logic emit_valid;
    logic emit_ready;
    logic slot_bit;
    owm_rsp_type emit_rsp;
    logic [17:0] buf_out;

    assign slot_bit = shift_reg[0];
    assign emit_valid = (state_reg == ST_EMIT);
    assign emit_rsp = '{data: shift_reg, crc: crc_reg, presence: presence_reg,
                        line_stuck: stuck_reg};

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    // line left high between requests; device resumes later
                    // query byte and its answer ride plain byte slots
                    if (i_req_valid) begin
                        cnt_reg <= '0;
                        if (i_req.op == OWM_OP_RESET || i_req.op == OWM_OP_HARD_RESET) begin
                            state_reg <= ST_RST_LOW;
                        end else if (i_req.op == OWM_OP_CRC_CLR) begin
                            state_reg <= ST_EMIT;
                        end else begin
                            state_reg <= ST_SLOT_LOW;
                        end
                    end
                end
                ST_RST_LOW: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if ((op_reg == OWM_OP_HARD_RESET && cnt_reg == CW'(HARD_RESET_CYCLES - 1))
                        || (op_reg == OWM_OP_RESET && cnt_reg == CW'(RESET_CYCLES - 1))) begin
                        cnt_reg <= '0;
                        state_reg <= ST_RST_CHECK;
                    end
                end
                ST_RST_CHECK: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == CW'(PRESENCE_CHECK_CYC - 1)) begin
                        state_reg <= ST_RST_WAIT;
                    end
                end
                ST_RST_WAIT: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == CW'(PRESENCE_WIN_CYCLES - 1)) begin
                        state_reg <= ST_EMIT;
                    end
                end
                ST_SLOT_LOW: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == CW'(WRITE_SLOT_STROBE_CYC - 1)) begin
                        state_reg <= ST_SLOT_HOLD;
                    end
                end
                ST_SLOT_HOLD: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == CW'(SLOT_CYCLES - RECOVERY_CYC - 1)) begin
                        state_reg <= ST_SLOT_REC;
                    end
                end
                ST_SLOT_REC: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == CW'(SLOT_CYCLES - 1)) begin
                        cnt_reg <= '0;
                        state_reg <= (bit_reg == 3'h7) ? ST_EMIT : ST_SLOT_LOW;
                    end
                end
                ST_EMIT: begin
                    if (emit_ready) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // line drive: open drain, oe high pulls low
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            line_oe_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    line_oe_reg <= i_req_valid && (i_req.op != OWM_OP_CRC_CLR);
                end
                ST_RST_LOW: begin
                    line_oe_reg <= !((op_reg == OWM_OP_HARD_RESET
                                      && cnt_reg == CW'(HARD_RESET_CYCLES - 1))
                                     || (op_reg == OWM_OP_RESET
                                         && cnt_reg == CW'(RESET_CYCLES - 1)));
                end
                ST_SLOT_LOW: begin
                    // write zero keeps low, write one and read release
                    if (cnt_reg == CW'(WRITE_SLOT_STROBE_CYC - 1)) begin
                        line_oe_reg <= (op_reg == OWM_OP_WRITE) && !slot_bit;
                    end
                end
                ST_SLOT_HOLD: begin
                    if (cnt_reg == CW'(SLOT_CYCLES - RECOVERY_CYC - 1)) begin
                        line_oe_reg <= 1'b0;
                    end
                end
                ST_SLOT_REC: begin
                    line_oe_reg <= (cnt_reg == CW'(SLOT_CYCLES - 1)) && (bit_reg != 3'h7);
                end
                default: begin
                    line_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // data, bit count and check value
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            op_reg <= OWM_OP_RESET;
            shift_reg <= 8'h00;
            bit_reg <= 3'h0;
            crc_reg <= CRC_INIT;
        end else begin
            if (state_reg == ST_IDLE && i_req_valid) begin
                op_reg <= i_req.op;
                shift_reg <= (i_req.op == OWM_OP_READ) ? 8'h00 : i_req.data;
                bit_reg <= 3'h0;
                // own check restarts at each reset or on request
                if (i_req.op == OWM_OP_RESET || i_req.op == OWM_OP_HARD_RESET
                    || i_req.op == OWM_OP_CRC_CLR) begin
                    crc_reg <= CRC_INIT;
                end
            end
            if (state_reg == ST_SLOT_HOLD && cnt_reg == CW'(READ_SAMPLE_CYC - 1)) begin
                // sampled bit (driven or read back) feeds the check
                shift_reg <= {(op_reg == OWM_OP_READ) ? i_line : slot_bit, shift_reg[7:1]};
                crc_reg <= crc_step(crc_reg, (op_reg == OWM_OP_READ) ? i_line : slot_bit);
            end
            if (state_reg == ST_SLOT_REC && cnt_reg == CW'(SLOT_CYCLES - 1)) begin
                bit_reg <= bit_reg + 3'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // presence capture
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            presence_reg <= 1'b0;
            stuck_reg <= 1'b0;
        end else begin
            if (state_reg == ST_RST_LOW) begin
                presence_reg <= 1'b0;
                stuck_reg <= 1'b0;
            end
            // line must be back high before the presence pulse
            if (state_reg == ST_RST_CHECK && cnt_reg == CW'(PRESENCE_CHECK_CYC - 1)) begin
                stuck_reg <= !i_line;
            end
            // both reset lengths look for a presence pulse
            if (state_reg == ST_RST_WAIT && !i_line && !stuck_reg) begin
                presence_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // answer buffer; a stalled consumer holds the master in emit once two answers wait
    // ----------------------------------------------------------------
    owm_skid #(
        .WIDTH(18),
        .DEPTH(2)
    ) u_skid (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_in_valid(emit_valid),
        .o_in_ready(emit_ready),
        .i_in_data(emit_rsp),
        .o_out_valid(o_rsp_valid),
        .i_out_ready(i_rsp_ready),
        .o_out_data(buf_out)
    );

    assign o_rsp = owm_rsp_type'(buf_out);
    assign o_line = 1'b0;
    assign o_line_oe = line_oe_reg;
    assign o_req_ready = (state_reg == ST_IDLE);
    assign o_busy = (state_reg != ST_IDLE);

endmodule : owm_master

// ===== owm_master_assertions.sv
/* owm_master_chk: port timing checks for the link master.
   assumes one clock domain; attached to owm_master by the bind below. */
`timescale 1ns/100ps
module owm_master_chk import owm_pkg::*; #(
    parameter int unsigned HARD_RESET_CYCLES = HARD_RESET_CYC,
    parameter int unsigned RESET_CYCLES = RESET_LOW_CYC,
    parameter int unsigned SLOT_CYCLES = SLOT_CYC
) (
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_req_valid,
    input wire logic o_req_ready,
    input wire owm_req_type i_req,
    input wire logic o_rsp_valid,
    input wire logic i_rsp_ready,
    input wire owm_rsp_type o_rsp,
    input wire logic o_busy,
    input wire logic o_line,
    input wire logic o_line_oe
);
    // ----
    // helper state: length of each low drive and the op that caused it
    // ----
    int unsigned oe_len_reg;
    owm_op_type op_reg;
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) oe_len_reg <= 0;
        else oe_len_reg <= o_line_oe ? oe_len_reg + 1 : 0;
    end
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) op_reg <= OWM_OP_CRC_CLR;
        else if (i_req_valid && o_req_ready) op_reg <= i_req.op;
    end
    // ----
    // properties
    // ----
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    sequence s_oe_end;
        $fell(o_line_oe);
    endsequence
    sequence s_end_of(owm_op_type op);
        $fell(o_line_oe) && op_reg == op;
    endsequence
    AST_OPEN_DRAIN: assert property (o_line == 1'b0)
        else $error("line driven high");
    AST_IDLE_REL: assert property (!o_busy |-> !o_line_oe)
        else $error("line held while idle");
    AST_RESET_LEN: assert property (s_end_of(OWM_OP_RESET) |-> oe_len_reg inside {[RESET_CYCLES:RESET_CYCLES+1]})
        else $error("reset low length wrong");
    AST_HARD_LEN: assert property (s_end_of(OWM_OP_HARD_RESET) |-> oe_len_reg inside {[HARD_RESET_CYCLES:HARD_RESET_CYCLES+1]})
        else $error("hard reset length wrong");
    AST_WR_SLOT: assert property (s_end_of(OWM_OP_WRITE) |-> oe_len_reg >= WRITE_SLOT_STROBE_CYC && oe_len_reg <= SLOT_CYCLES - RECOVERY_CYC + 1)
        else $error("write slot low length wrong");
    AST_RD_SLOT: assert property (s_end_of(OWM_OP_READ) |-> oe_len_reg inside {[READ_SLOT_STROBE_CYC:READ_SLOT_STROBE_CYC+1]})
        else $error("read strobe length wrong");
    AST_RECOVER: assert property (s_oe_end |-> !o_line_oe [*8])
        else $error("no recovery after slot");
    AST_RSP_HOLD: assert property (o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp))
        else $error("answer changed while stalled");
endmodule : owm_master_chk

bind owm_master owm_master_chk #(
    .HARD_RESET_CYCLES(HARD_RESET_CYCLES),
    .RESET_CYCLES(RESET_CYCLES),
    .SLOT_CYCLES(SLOT_CYCLES)
) i_chk (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_req(i_req), .o_rsp_valid(o_rsp_valid),
    .i_rsp_ready(i_rsp_ready), .o_rsp(o_rsp), .o_busy(o_busy), .o_line(o_line),
    .o_line_oe(o_line_oe));

// ===== owm_dev_model.sv
/* owm_dev_model: behavioural single-wire memory device for the master bench.
   assumes a pulled-up line on i_line and i_mclk only as a timebase. */
`timescale 1ns/100ps
module owm_dev_model import owm_pkg::*; #(
    parameter int RST_MIN = 3500,
    parameter int PRES_DLY = 3800,
    parameter int PRES_LEN = 500
) (
    input wire logic i_mclk,
    input wire logic i_line,
    input wire logic i_mute,
    output logic o_drive
);
    // ----
    // slot engine: read rom 33h is taken as skip, no rom is sent
    // ----
    int n;
    int nbit;
    int phase;
    logic bit_in;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] dcrc;
    initial begin
        o_drive = 1'b0;
        phase = 0;
        nbit = 0;
        sh = 8'h00;
        tx = 8'hFF;
        dcrc = 8'h00;
        forever begin
            @(negedge i_line iff !o_drive); // idle of any length waits here
            n = 0;
            bit_in = 1'b1;
            if (phase == 2 && !tx[0] && !i_mute) o_drive = 1'b1;
            while (i_line == 1'b0 && n < 2000000) begin
                @(posedge i_mclk);
                n++;
                if (n == 1000) bit_in = i_line;
                if (n == 3400) o_drive = 1'b0;
            end
            if (n >= RST_MIN) begin
                phase = 0;
                nbit = 0;
                dcrc = 8'h00;
                if (!i_mute) begin
                    repeat (PRES_DLY) @(posedge i_mclk);
                    o_drive = 1'b1;
                    repeat (PRES_LEN) @(posedge i_mclk);
                    o_drive = 1'b0;
                end
            end else if (phase < 2) begin
                sh = {bit_in, sh[7:1]};
                // received bytes feed the device check
                dcrc = (dcrc[0] ^ bit_in) ? (dcrc >> 1) ^ CRC_POLY_REFL : dcrc >> 1;
                nbit++;
                if (nbit == 8) begin
                    nbit = 0;
                    if (phase == 0 && (sh == CMD_SKIP_ROM || sh == CMD_READ_ROM)) begin
                        phase = 1;
                    // no check compare here, never aborts
                    // 5Ah is ignored in every phase; the model has no write mode
                    end else if (phase == 1 && sh == CMD_PROFILE) begin
                        phase = 2;
                        tx = PROFILE_ANSWER;
                    end
                end
            end else if (phase == 2) begin
                tx = {1'b1, tx[7:1]};
                nbit++;
                if (nbit == 8) phase = 3; // ones from now on
            end
        end
    end
endmodule : owm_dev_model

// ===== test_owm_master.sv
/* test_owm_master: self-checking bench for the link master and a device model.
   assumes owm_pkg, owm_master, owm_dev_model and the checker are compiled. */
`timescale 1ns/100ps
module test_owm_master import owm_pkg::*;;
    // ----
    // set-up: counts shortened so a zero bit stays below the reset length
    // ----
    localparam int unsigned HARD_T = 4000;
    localparam int unsigned RESET_T = 3700;
    localparam int unsigned WIN_T = 5000;
    localparam int unsigned SLOT_T = 4600;
    localparam int unsigned RUN_T = 3 * (HARD_T + WIN_T) + 24 * SLOT_T + 20000;
    typedef struct {int kind; owm_rsp_type rsp;} owm_note_type;
    logic mclk, resetn, req_valid, req_ready, rsp_valid, rsp_ready;
    logic line_o, line_oe, drv, mute, stall, busy;
    logic [31:0] r;
    logic [7:0] crc_exp;
    wire line;
    owm_req_type req;
    owm_rsp_type rsp;
    owm_note_type exp_q[$];
    owm_note_type got;
    int seed, fail_count, checks_done;
    assign line = (line_oe ? line_o : 1'b1) & !drv;
    owm_master #(.HARD_RESET_CYCLES(HARD_T), .RESET_CYCLES(RESET_T),
        .PRESENCE_WIN_CYCLES(WIN_T), .SLOT_CYCLES(SLOT_T)) i_dut (
        .i_mclk(mclk), .i_resetn(resetn), .i_req_valid(req_valid),
        .o_req_ready(req_ready), .i_req(req), .o_rsp_valid(rsp_valid),
        .i_rsp_ready(rsp_ready), .o_rsp(rsp), .o_busy(busy), .i_line(line),
        .o_line(line_o), .o_line_oe(line_oe));
    owm_dev_model i_dev (.i_mclk(mclk), .i_line(line), .i_mute(mute), .o_drive(drv));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        #1;
        r = $random(seed);
        rsp_ready = !stall && r[1:0] != 2'h0;
    end
    // ----
    // tasks
    // ----
    function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] d);
        for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
        return c;
    endfunction : crc_byte
    task automatic fail_msg(input string m);
        fail_count++;
        $display("Error at %0t: %s", $time, m);
    endtask : fail_msg
    task automatic check_link(input owm_rsp_type g, input owm_rsp_type e);
        checks_done++;
        if ({g.presence, g.line_stuck} !== {e.presence, e.line_stuck}) fail_msg("presence");
    endtask : check_link
    task automatic check_byte(input owm_rsp_type g, input owm_rsp_type e);
        checks_done++;
        if ({g.data, g.crc} !== {e.data, e.crc}) fail_msg("byte or check value");
    endtask : check_byte
    task automatic check_crc(input owm_rsp_type g, input owm_rsp_type e);
        checks_done++;
        if (g.crc !== e.crc) fail_msg("check value");
    endtask : check_crc
    task automatic check_bit(input logic g, input logic e, input string m);
        checks_done++;
        if (g !== e) fail_msg(m);
    endtask : check_bit
    task automatic note(input int kind, input logic [7:0] d, input logic pres);
        owm_note_type e;
        e.kind = kind;
        e.rsp = '{data: d, crc: crc_exp, presence: pres, line_stuck: 1'b0};
        exp_q.push_back(e);
    endtask : note
    task automatic send(input owm_op_type op, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        #1;
        req_valid = 1'b1;
        req = '{op: op, data: d};
        @(posedge mclk);
        while (req_ready !== 1'b1 && n < 60000) begin
            @(posedge mclk);
            n++;
        end
        #1;
        req_valid = 1'b0;
        if (n >= 60000) fail_msg("request not taken");
    endtask : send
    task automatic wait_quiet();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 60000) begin
            @(posedge mclk);
            n++;
        end
        #1;
        if (n >= 60000) fail_msg("answer missing");
    endtask : wait_quiet
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    // ----
    // answer watcher: oldest note against each answer taken
    // ----
    always @(posedge mclk) begin
        if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail_msg("unexpected answer");
            end else begin
                got = exp_q.pop_front();
                if (got.kind == 0) check_link(rsp, got.rsp);
                else if (got.kind == 1) check_byte(rsp, got.rsp);
                else check_crc(rsp, got.rsp);
            end
        end
    end
    initial begin
        #(RUN_T * 4);
        fail_msg("watchdog expired");
        conclude();
    end
    // ----
    // scenarios
    // ----
    initial begin
        seed = 59424;
        {fail_count, checks_done} = '0;
        {resetn, req_valid, mute, stall} = '0;
        req = '0;
        crc_exp = CRC_INIT;
        repeat (3) @(posedge mclk);
        #1;
        resetn = 1'b1;
        note(0, 8'h00, 1'b1);
        send(OWM_OP_HARD_RESET, 8'h00);
        wait_quiet();
        mute = 1'b1;
        note(0, 8'h00, 1'b0);
        send(OWM_OP_RESET, 8'h00);
        wait_quiet();
        mute = 1'b0;
        note(0, 8'h00, 1'b1);
        send(OWM_OP_RESET, 8'h00);
        wait_quiet();
        $display("reset and presence test done");
        stall = 1'b1;
        repeat (3) begin
            note(2, 8'h00, 1'b0);
            send(OWM_OP_CRC_CLR, 8'h00);
        end
        repeat (20) @(posedge mclk);
        #1;
        check_bit(req_ready, 1'b0, "full buffer not refusing");
        check_bit(busy, 1'b1, "stalled master not busy");
        stall = 1'b0;
        wait_quiet();
        @(posedge mclk);
        #1;
        check_bit(rsp_valid, 1'b0, "buffer not empty");
        check_bit(busy, 1'b0, "drained master still busy");
        $display("buffer test done");
        crc_exp = crc_byte(crc_exp, CMD_SKIP_ROM);
        note(1, CMD_SKIP_ROM, 1'b0);
        send(OWM_OP_WRITE, CMD_SKIP_ROM);
        crc_exp = crc_byte(crc_exp, CMD_PROFILE);
        note(1, CMD_PROFILE, 1'b0);
        send(OWM_OP_WRITE, CMD_PROFILE);
        wait_quiet();
        check_bit(i_dev.dcrc === crc_exp, 1'b1, "device check value differs");
        repeat (2000) @(posedge mclk); // idle pause mid transaction
        crc_exp = crc_byte(crc_exp, PROFILE_ANSWER);
        note(1, PROFILE_ANSWER, 1'b0);
        send(OWM_OP_READ, 8'hFF);
        wait_quiet();
        $display("profile query test done");
        conclude();
    end
endmodule : test_owm_master
